// File: logic/ppo_pkg.sv
package ppo_pkg;

  // ****************************************************************
  // Port geometry
  // ****************************************************************
  localparam int unsigned PINS = 8;               // Pins in one port
  localparam int unsigned AW   = 4;               // Byte address width
  localparam int unsigned DW   = 32;              // Bus data width

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [AW-1:0] OFS_DIR    = 4'h0;    // Direction bits
  localparam logic [AW-1:0] OFS_OUT    = 4'h4;    // Output value bits
  localparam logic [AW-1:0] OFS_IN     = 4'h8;    // Input sample / toggle
  localparam logic [AW-1:0] OFS_MCUCTL = 4'hC;    // Control register

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int unsigned   KILL_BIT   = 4;       // Global pull-up kill
  localparam logic [7:0]    DIR_RST    = 8'h00;   // All pins inputs
  localparam logic [7:0]    OUT_RST    = 8'h00;   // All values low
  localparam logic [7:0]    MCUCTL_RST = 8'h00;   // Pull-ups allowed

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned   SYNC_STAGES = 2;      // Pin to sample bit delay
  localparam int unsigned   BUS_WAIT    = 1;      // Wait states per access

  // Bus handshake state
  typedef enum logic [0:0] {
    PPO_BUS_IDLE = 1'b0,                          // Request not yet served
    PPO_BUS_ACK  = 1'b1                           // Answer in this cycle
  } ppo_bus_t;

endpackage

// File: logic/ppo_port_cell.sv
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Behaviour
// RL1 - Deep sleep clamps digital inputs to ground
// RL2 - Enabled external interrupt pins escape the clamp
// RL3 - Clamp release on high pin sets flag
// RL4 - Pull-ups forced off while reset is active
// RL5 - Software should give unused pins defined levels
// RL6 - Default pull-up when dir,out,kill equal 010
// RL7 - Pull-up override value rules when enabled
// RL8 - Driver enable from override or direction bit
// RL9 - Driven level from override or output bit
// RL10 - Toggle override inverts stored output bit
// RL11 - Input enable from override or chip state
// RL12 - Alternate feed taken before the synchroniser
// RL13 - Strobes per port, clamp and kill shared
// RL14 - Peripherals drive their own override signals
// RL15 - Direction one drives output, zero is input
// RL16 - Writing one to input register toggles output
// RL17 - Control bit 4 kills all pull-ups; the code still lets pullup_ovr_en pins set their pull-up from pullup_ovr_val
// RL18 - Pin level sampled through two-stage synchroniser
// RL19 - Reset clears direction and output, pins tri-state
// RL20 - Toggle acts before the level override mux
module ppo_port_cell (
  // Clock and reset
  input  wire logic                        clock,
  input  wire logic                        sys_rst,
  // Avalon-MM register slave
  input  wire logic [ppo_pkg::AW-1:0]      avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [ppo_pkg::DW-1:0]      avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output logic      [ppo_pkg::DW-1:0]      avs_readdata,
  output logic                             avs_waitrequest,
  // Sleep controller and external interrupt unit
  input  wire logic                        deep_sleep,
  input  wire logic [ppo_pkg::PINS-1:0]    ext_irq_enable,
  input  wire logic [ppo_pkg::PINS-1:0]    ext_irq_edge_sense,
  output logic      [ppo_pkg::PINS-1:0]    ext_irq_flag_set,
  // Alternate-function overrides, one per pin
  input  wire logic [ppo_pkg::PINS-1:0]    pullup_ovr_en,
  input  wire logic [ppo_pkg::PINS-1:0]    pullup_ovr_val,
  input  wire logic [ppo_pkg::PINS-1:0]    dir_ovr_en,
  input  wire logic [ppo_pkg::PINS-1:0]    dir_ovr_val,
  input  wire logic [ppo_pkg::PINS-1:0]    level_ovr_en,
  input  wire logic [ppo_pkg::PINS-1:0]    level_ovr_val,
  input  wire logic [ppo_pkg::PINS-1:0]    invert_ovr_en,
  input  wire logic [ppo_pkg::PINS-1:0]    input_gate_ovr_en,
  input  wire logic [ppo_pkg::PINS-1:0]    input_gate_ovr_val,
  output logic      [ppo_pkg::PINS-1:0]    alt_logic_feed,
  // Pad
  input  wire logic [ppo_pkg::PINS-1:0]    pad_in,
  output logic      [ppo_pkg::PINS-1:0]    pad_out,
  output logic      [ppo_pkg::PINS-1:0]    pad_oe,
  output logic      [ppo_pkg::PINS-1:0]    pad_pullup_on,
  // Shared control towards other ports
  output logic                             global_pullup_kill
);
  import ppo_pkg::*;

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [PINS-1:0] pin_direction_bit_q;           // Direction register
  logic [PINS-1:0] pin_direction_bit_d;           // Next direction
  logic [PINS-1:0] pin_output_value_bit_q;        // Output value register
  logic [PINS-1:0] pin_output_value_bit_d;        // Next output value
  logic [PINS-1:0] sync_first_q;                  // First sync stage
  logic [PINS-1:0] pin_input_sample_bit_q;        // Input sample register
  logic [PINS-1:0] sample_prev_q;                 // Previous sample
  logic [7:0]      mcu_control_reg_q;             // Control register
  logic [7:0]      mcu_control_reg_d;             // Next control value
  ppo_bus_t        bus_state_q;                   // Handshake state
  ppo_bus_t        bus_state_d;                   // Next handshake state
  logic [DW-1:0]   readdata_q;                    // Registered read data
  logic [DW-1:0]   readdata_d;                    // Next read data

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  // Byte offset match helper, used for every register select
  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [AW-1:0] ofs);
    hit = (a == ofs);
  endfunction

  wire       bus_req   = avs_read | avs_write;    // Any request pending
  wire       bus_take  = bus_req & (bus_state_q == PPO_BUS_ACK);
  wire       wr_lane0  = avs_write & bus_take & avs_byteenable[0];
  wire       wr_dir    = wr_lane0 & hit(avs_address, OFS_DIR);
  wire       wr_out    = wr_lane0 & hit(avs_address, OFS_OUT);
  wire       wr_in     = wr_lane0 & hit(avs_address, OFS_IN);
  wire       wr_ctl    = wr_lane0 & hit(avs_address, OFS_MCUCTL);
  wire [7:0] wbyte     = avs_writedata[7:0];      // Low lane write byte

  // One wait state, then the answer
  assign avs_waitrequest = bus_req & (bus_state_q != PPO_BUS_ACK);
  assign avs_readdata    = readdata_q;
  assign bus_state_d     = (bus_req & (bus_state_q == PPO_BUS_IDLE))
                           ? PPO_BUS_ACK : PPO_BUS_IDLE;

  // Read mux, unmapped offsets read zero
  assign readdata_d =
      hit(avs_address, OFS_DIR)    ? {24'h000000, pin_direction_bit_q}
    : hit(avs_address, OFS_OUT)    ? {24'h000000, pin_output_value_bit_q}
    : hit(avs_address, OFS_IN)     ? {24'h000000, pin_input_sample_bit_q}
    : hit(avs_address, OFS_MCUCTL) ? {24'h000000, mcu_control_reg_q}
    : 32'h00000000;

  // ****************************************************************
  // Register next values
  // ****************************************************************
  // Per-port strobes reach all pins alike [RL13]
  assign pin_direction_bit_d = wr_dir ? wbyte : pin_direction_bit_q;
  // Input-register write ones and toggle override flip the stored bit,
  // before the level override mux [RL16] [RL10] [RL20]
  assign pin_output_value_bit_d =
    (wr_out ? wbyte : pin_output_value_bit_q)
    ^ (wr_in ? wbyte : 8'h00) ^ invert_ovr_en;
  // Only the kill bit is writable in the control register
  assign mcu_control_reg_d = wr_ctl
    ? (wbyte & (8'h01 << KILL_BIT)) : mcu_control_reg_q;
  assign global_pullup_kill = mcu_control_reg_q[KILL_BIT]; // [RL17]

  // ****************************************************************
  // Per-pin cell
  // ****************************************************************
  logic [PINS-1:0] input_enable;                  // Digital input enable
  logic [PINS-1:0] gated_in;                      // Clamped pad level

  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi = gi + 1) begin : g_pin
      // Chip-state enable: clamp in deep sleep unless ext irq [RL1] [RL2]
      wire state_en = ~deep_sleep | ext_irq_enable[gi];
      // Override takes the input enable when asserted [RL11]
      assign input_enable[gi] = input_gate_ovr_en[gi]
                                ? input_gate_ovr_val[gi] : state_en;
      // Clamp to ground ahead of the schmitt stage [RL1]
      assign gated_in[gi] = pad_in[gi] & input_enable[gi];
      // Driver enable from override or direction bit [RL8] [RL15]
      assign pad_oe[gi] = dir_ovr_en[gi] ? dir_ovr_val[gi]
                                         : pin_direction_bit_q[gi];
      // Driven level from override or stored value [RL9] [RL20]
      assign pad_out[gi] = level_ovr_en[gi] ? level_ovr_val[gi]
                                            : pin_output_value_bit_q[gi];
      // Pull-up: override, else {dir,out,kill} == 010, never in reset
      assign pad_pullup_on[gi] = ~sys_rst & (pullup_ovr_en[gi]   // [RL4]
        ? pullup_ovr_val[gi]                                     // [RL7]
        : ({pin_direction_bit_q[gi], pin_output_value_bit_q[gi],
            global_pullup_kill} == 3'h2));                       // [RL6]
    end
  endgenerate

  // Alternate functions see the level before the synchroniser [RL12]
  assign alt_logic_feed = gated_in;

  // Clamp release on a high pin looks like an edge, flag it [RL3]
  assign ext_irq_flag_set = ext_irq_edge_sense
    & (pin_input_sample_bit_q ^ sample_prev_q);

  // ****************************************************************
  // Clocked state
  // ****************************************************************
  // Registers clear to inputs with values low, pins tri-state [RL19]
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pin_direction_bit_q    <= DIR_RST;
      pin_output_value_bit_q <= OUT_RST;
      mcu_control_reg_q      <= MCUCTL_RST;
    end else begin
      pin_direction_bit_q    <= pin_direction_bit_d;
      pin_output_value_bit_q <= pin_output_value_bit_d;
      mcu_control_reg_q      <= mcu_control_reg_d;
    end
  end

  // Input synchroniser and edge history [RL18]
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sync_first_q           <= 8'h00;
      pin_input_sample_bit_q <= 8'h00;
      sample_prev_q          <= 8'h00;
    end else begin
      sync_first_q           <= gated_in;
      pin_input_sample_bit_q <= sync_first_q;
      sample_prev_q          <= pin_input_sample_bit_q;
    end
  end

  // Bus handshake and read data
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bus_state_q <= PPO_BUS_IDLE;
      readdata_q  <= 32'h00000000;
    end else begin
      bus_state_q <= bus_state_d;
      readdata_q  <= readdata_d;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_req_start;
    bus_req && bus_state_q == PPO_BUS_IDLE;
  endsequence

  sequence s_answer;
    !avs_waitrequest;
  endsequence

  property p_one_wait;
    @(posedge clock) disable iff (sys_rst)
      s_req_start |-> avs_waitrequest ##1 s_answer;
  endproperty

  a_bus_one_wait: assert property (p_one_wait)
    else $error("bus answer not after one wait state");

  a_pullup_in_reset: assert property ( // [RL4]
    @(posedge clock) sys_rst |-> pad_pullup_on == 8'h00)
    else $error("pull-up on during reset");

  a_pullup_default: assert property ( // [RL6]
    @(posedge clock) disable iff (sys_rst)
      pad_pullup_on[0] == (pullup_ovr_en[0] ? pullup_ovr_val[0]
        : (!pin_direction_bit_q[0] && pin_output_value_bit_q[0]
           && !global_pullup_kill)))
    else $error("pull-up pin 0 wrong");

  a_kill_pullups: assert property ( // [RL17]
    @(posedge clock) disable iff (sys_rst)
      global_pullup_kill |-> (pad_pullup_on & ~pullup_ovr_en) == 8'h00)
    else $error("pull-up on despite kill");

  a_sleep_clamp: assert property ( // [RL1]
    @(posedge clock) disable iff (sys_rst)
      deep_sleep |-> (alt_logic_feed & ~ext_irq_enable
                      & ~input_gate_ovr_en) == 8'h00)
    else $error("input not clamped in deep sleep");

  a_irq_no_clamp: assert property ( // [RL2]
    @(posedge clock) disable iff (sys_rst)
      (ext_irq_enable == 8'hFF && input_gate_ovr_en == 8'h00)
      |-> alt_logic_feed == pad_in)
    else $error("interrupt pin clamped");

  a_sync_delay: assert property ( // [RL18]
    @(posedge clock) disable iff (sys_rst)
      ##2 pin_input_sample_bit_q == $past(gated_in, 2))
    else $error("sample not two cycles behind pad");

  a_dir_select: assert property ( // [RL8]
    @(posedge clock) disable iff (sys_rst)
      (!dir_ovr_en[0] && $rose(pin_direction_bit_q[0])) |-> pad_oe[0])
    else $error("driver enable not following direction");

  a_toggle_write: assert property ( // [RL16]
    @(posedge clock) disable iff (sys_rst)
      (wr_in && wbyte[0] && !wr_out && !invert_ovr_en[0])
      |=> pin_output_value_bit_q[0] != $past(pin_output_value_bit_q[0]))
    else $error("input write did not toggle");

  a_level_override: assert property ( // [RL9]
    @(posedge clock) disable iff (sys_rst)
      level_ovr_en[0] |-> pad_out[0] == level_ovr_val[0])
    else $error("level override ignored");

endmodule

// File: testbench/ppo_pad_model.sv
`timescale 1ns/1ps
module ppo_pad_model (
  // Clock
  input  wire logic       clock,
  // Device side of the pad
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup_on,
  // Board side drive, per pin
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pad_in
);
  logic [7:0] float_q = 8'h5A; // Level of a pin nobody holds

  // An undriven pin wanders every cycle so stale levels never pass
  always_ff @(posedge clock) begin
    float_q <= ~float_q;
  end

  // Device driver wins, then the board, then the pull-up
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
                | (~pad_oe & ~ext_en & (pad_pullup_on | float_q));
endmodule

// File: testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import ppo_pkg::*;
  // Bus, clock and reset
  logic          clock = 1'b0, sys_rst = 1'b1, deep_sleep = 1'b0;
  logic [AW-1:0] avs_address = 4'h0;
  logic          avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [DW-1:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [3:0]    avs_byteenable = 4'hF;
  // Pin vectors: overrides, pad, interrupt unit
  logic [7:0] pullup_ovr_en = 8'hFF, pullup_ovr_val = 8'hFF;
  logic [7:0] dir_ovr_en = 8'h00, dir_ovr_val = 8'h00, level_ovr_en = 8'h00;
  logic [7:0] level_ovr_val = 8'h00, invert_ovr_en = 8'h00;
  logic [7:0] input_gate_ovr_en = 8'h00, input_gate_ovr_val = 8'h00;
  logic [7:0] ext_irq_enable = 8'h00, ext_irq_edge_sense = 8'h00;
  logic [7:0] ext_en = 8'hFF, ext_val = 8'h00, ext_irq_flag_set;
  logic [7:0] alt_logic_feed, pad_in, pad_out, pad_oe, pad_pullup_on;
  logic       global_pullup_kill, kill_m;
  logic [7:0] dir_m, out_m;       // Expected register contents
  int         miscompares = 0, n_checks = 0;

  always #20 clock = ~clock;

  ppo_port_cell ppo_port_cell_i (.clock, .sys_rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .deep_sleep, .ext_irq_enable, .ext_irq_edge_sense,
    .ext_irq_flag_set, .pullup_ovr_en, .pullup_ovr_val, .dir_ovr_en,
    .dir_ovr_val, .level_ovr_en, .level_ovr_val, .invert_ovr_en,
    .input_gate_ovr_en, .input_gate_ovr_val, .alt_logic_feed, .pad_in,
    .pad_out, .pad_oe, .pad_pullup_on, .global_pullup_kill);
  ppo_pad_model ppo_pad_model_i (.clock, .pad_out, .pad_oe, .pad_pullup_on,
    .ext_en, .ext_val, .pad_in);

  // ****************************************************************
  // Compare, bus and closing tasks
  // ****************************************************************
  task automatic chk_pin(input string nm, input logic [7:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bus(input string nm, input logic [DW-1:0] e, g);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic results();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One Avalon access, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [AW-1:0] a,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      results();
    end
  endtask

  // Expected pad controls from the bench's register copy
  function automatic logic [7:0] exp_pu();
    return (pullup_ovr_en & pullup_ovr_val)
         | (~pullup_ovr_en & ~dir_m & out_m & {8{~kill_m}});
  endfunction
  function automatic logic [7:0] exp_oe();
    return (dir_ovr_en & dir_ovr_val) | (~dir_ovr_en & dir_m);
  endfunction
  function automatic logic [7:0] exp_lv();
    return (level_ovr_en & level_ovr_val) | (~level_ovr_en & out_m);
  endfunction
  function automatic logic [7:0] exp_gate();
    return (input_gate_ovr_en & input_gate_ovr_val)
         | (~input_gate_ovr_en & ~({8{deep_sleep}} & ~ext_irq_enable));
  endfunction
  task automatic check_pins();
    chk_pin("pullup", exp_pu(), pad_pullup_on);
    chk_pin("oe", exp_oe(), pad_oe);
    chk_pin("level", exp_lv() & exp_oe(), pad_out & exp_oe());
    chk_pin("feed", pad_in & exp_gate(), alt_logic_feed);
    chk_pin("kill", {7'h0, kill_m}, {7'h0, global_pullup_kill});
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    int s;
    logic [7:0] acc;
    s = $urandom(32'h0546);
    {dir_m, out_m, kill_m} = 17'h0;
    repeat (16) @(posedge clock);
    #1;
    chk_pin("rst_pullup", 8'h00, pad_pullup_on);
    chk_pin("rst_oe", 8'h00, pad_oe);
    @(posedge clock);
    sys_rst <= 1'b0;
    pullup_ovr_en <= 8'h00;
    // Reset values, unmapped place, masked byte lane
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, AW'(i * 4), 8'h00);
      chk_bus("reset_reg", 32'h0, rd);
    end
    bus(1'b1, 4'h2, 8'hFF);
    bus(1'b0, 4'h2, 8'h00);
    chk_bus("unmapped", 32'h0, rd);
    avs_byteenable <= 4'hE;
    bus(1'b1, OFS_DIR, 8'hFF);
    avs_byteenable <= 4'hF;
    bus(1'b0, OFS_DIR, 8'h00);
    chk_bus("lane_gate", 32'h0, rd);
    // Random registers, overrides, sleep and pad levels
    repeat (40) begin
      dir_m = 8'($urandom);
      out_m = 8'($urandom);
      kill_m = 1'($urandom);
      bus(1'b1, OFS_DIR, dir_m);
      bus(1'b1, OFS_OUT, out_m);
      bus(1'b1, OFS_MCUCTL, {3'($urandom), kill_m, 4'($urandom)});
      {pullup_ovr_en, pullup_ovr_val, dir_ovr_en, dir_ovr_val} <= $urandom;
      {level_ovr_en, level_ovr_val, input_gate_ovr_en,
       input_gate_ovr_val} <= $urandom;
      {ext_irq_enable, ext_en, ext_val} <= 24'($urandom);
      deep_sleep <= 1'($urandom);
      repeat (3) @(posedge clock);
      #1;
      check_pins();
      bus(1'b0, OFS_MCUCTL, 8'h00);
      chk_bus("control", {27'h0, kill_m, 4'h0}, rd);
      acc = exp_oe() | ext_en | exp_pu();
      bus(1'b0, OFS_IN, 8'h00);
      chk_pin("sample", pad_in & exp_gate() & acc, rd[7:0] & acc);
    end
    // Software toggle, toggle override, then value override on top
    {pullup_ovr_en, dir_ovr_en, level_ovr_en, input_gate_ovr_en} <= 32'h0;
    deep_sleep <= 1'b0;
    dir_m = 8'hFF;
    out_m = 8'h0F;
    bus(1'b1, OFS_DIR, dir_m);
    bus(1'b1, OFS_OUT, out_m);
    bus(1'b1, OFS_IN, 8'hC3);
    out_m ^= 8'hC3;
    bus(1'b0, OFS_OUT, 8'h00);
    chk_bus("soft_toggle", {24'h0, out_m}, rd);
    invert_ovr_en <= 8'h33;
    @(posedge clock);
    invert_ovr_en <= 8'h00;
    out_m ^= 8'h33;
    level_ovr_en <= 8'hF0;
    level_ovr_val <= 8'hA5;
    @(posedge clock);
    #1;
    check_pins();
    bus(1'b0, OFS_OUT, 8'h00);
    chk_bus("invert_ovr", {24'h0, out_m}, rd);
    // Clamp release on high edge-sensing pins raises their flags
    bus(1'b1, OFS_DIR, 8'h00);
    {level_ovr_en, ext_en, ext_val, ext_irq_edge_sense} <= 32'h00FFFFFF;
    ext_irq_enable <= 8'h0F;
    deep_sleep <= 1'b1;
    repeat (6) @(posedge clock);
    deep_sleep <= 1'b0;
    acc = 8'h00;
    repeat (6) begin
      @(posedge clock);
      #1;
      acc |= ext_irq_flag_set;
    end
    chk_pin("wake_flag", 8'hF0, acc);
    results();
  end
endmodule
